// ### logic/boot_pkg.sv
// Constants, types and CRC step for the EEPROM self boot loader.
// Assumes one master clock domain; all counts are in master clock cycles.
package boot_pkg;

    // ------------------------------------------------------------
    // Clocking and boot bus
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned SCL_DIV = 64;
    localparam logic [5:0] PH_DRIVE = 6'h08;
    localparam logic [5:0] PH_SAMPLE = 6'h30;
    localparam logic [5:0] PH_LAST = 6'(SCL_DIV - 1);
    localparam logic [6:0] EE_ADDR = 7'h50;
    localparam logic [2:0] HS_WR_ADDR = 3'h1;
    localparam logic [2:0] HS_LAST_LO = 3'h3;
    localparam logic [2:0] HS_RESTART = 3'h4;
    localparam logic [2:0] HS_RD_ADDR = 3'h5;

    // ------------------------------------------------------------
    // Instruction stream
    // ------------------------------------------------------------
    localparam logic [7:0] OP_END = 8'h00;
    localparam logic [7:0] OP_BURST = 8'h01;
    localparam logic [7:0] OP_DELAY = 8'h02;
    localparam logic [7:0] OP_NOP = 8'h03;
    localparam logic [7:0] OP_PLL = 8'h04;
    localparam logic [7:0] OP_SINGLE = 8'h05;
    localparam logic [2:0] ARGS_BURST = 3'h4;
    localparam logic [2:0] ARGS_DELAY = 3'h2;
    localparam logic [2:0] ARGS_SINGLE = 3'h3;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned BOOT_WAIT_CYC = 16568;
    localparam int unsigned RETRY_MS = 250;
    localparam int unsigned REF_KHZ = 12288;
    localparam int unsigned RETRY_CYC = RETRY_MS * REF_KHZ;
    localparam int unsigned DELAY_SHIFT = 11;
    localparam int CNT_W = 27;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_START = 3'b001,
        S_TX = 3'b010,
        S_TACK = 3'b011,
        S_RX = 3'b100,
        S_HOLD = 3'b101,
        S_MACK = 3'b110,
        S_STOP = 3'b111
    } bit_st_t;

    typedef enum logic [3:0] {
        M_OFF = 4'b0000,
        M_WAIT = 4'b0001,
        M_OP = 4'b0010,
        M_ARG = 4'b0011,
        M_DATA = 4'b0100,
        M_DELAY = 4'b0101,
        M_PLL = 4'b0110,
        M_CRC = 4'b0111,
        M_ABORT = 4'b1000,
        M_RETRY = 4'b1001,
        M_END = 4'b1010,
        M_DONE = 4'b1011
    } boot_st_t;

    function automatic logic [7:0] crc8_next(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

endpackage

// ### logic/boot_rd_if.sv
// Byte request channel between the boot sequencer and the EEPROM reader.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface boot_rd_if;
    logic req;
    logic stop;
    logic valid;
    logic err;
    logic idle;
    logic [7:0] data;

    modport seq (output req, output stop, input valid, input err, input idle, input data);
    modport engine (input req, input stop, output valid, output err, output idle, output data);
endinterface

// ### logic/eeprom_read_engine.sv
// Open-drain two-wire master that reads the EEPROM sequentially from location 0.
// Assumes external pull-ups; slave may stretch the clock while it is high.
`timescale 1ns/1ps
module eeprom_read_engine import boot_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    boot_rd_if.engine rd,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);

    bit_st_t st;
    logic [5:0] phase;
    logic [2:0] bitn;
    logic [2:0] hs;
    logic [7:0] sh;
    logic ack;
    logic samp;
    logic active;
    logic adv;
    logic step;

    function automatic logic [7:0] hdr_byte(input logic [2:0] n);
        unique case (n)
            HS_WR_ADDR: hdr_byte = {EE_ADDR, 1'b0};
            HS_RD_ADDR: hdr_byte = {EE_ADDR, 1'b1};
            default: hdr_byte = 8'h00;
        endcase
    endfunction

    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign rd.idle = (st == S_IDLE);
    assign active = (st != S_IDLE) && (st != S_HOLD);
    assign adv = active && !(phase[5] && !scl_oe && !scl_i);
    assign step = adv && (phase == PH_LAST);

    // ------------------------------------------------------------
    // Bit slot timing
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || !active) begin
            phase <= 6'h00;
        end else if (adv) begin
            phase <= phase + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            samp <= 1'b1;
        end else if (adv && phase == PH_SAMPLE) begin
            samp <= sda_i;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            scl_oe <= active ? !phase[5] : (st == S_HOLD);
            if (!active) begin
                sda_oe <= 1'b0;
            end else if (phase == PH_DRIVE || phase == PH_SAMPLE) begin
                unique case (st)
                    S_START: sda_oe <= (phase == PH_SAMPLE);
                    S_TX: sda_oe <= !sh[7];
                    S_MACK: sda_oe <= ack;
                    S_STOP: sda_oe <= (phase == PH_DRIVE);
                    default: sda_oe <= 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Transfer sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= S_IDLE;
            hs <= 3'h0;
            bitn <= 3'h0;
            sh <= 8'h00;
            ack <= 1'b0;
            rd.valid <= 1'b0;
            rd.err <= 1'b0;
            rd.data <= 8'h00;
        end else begin
            rd.valid <= 1'b0;
            rd.err <= 1'b0;
            unique case (st)
                S_IDLE: if (rd.req) begin
                    st <= S_START;
                    hs <= 3'h0;
                end
                S_HOLD: if (rd.req || rd.stop) begin
                    st <= S_MACK;
                    ack <= rd.req;
                end
                S_START: if (step) begin
                    hs <= hs + 3'h1;
                    sh <= hdr_byte(hs + 3'h1);
                    bitn <= 3'h7;
                    st <= S_TX;
                end
                S_TX: if (step) begin
                    sh <= {sh[6:0], 1'b0};
                    bitn <= bitn - 3'h1;
                    if (bitn == 3'h0) begin
                        st <= S_TACK;
                    end
                end
                S_TACK: if (step) begin
                    if (samp) begin
                        st <= S_STOP;
                        rd.err <= 1'b1;
                    end else if (hs == HS_LAST_LO) begin
                        st <= S_START;
                        hs <= HS_RESTART;
                    end else if (hs == HS_RD_ADDR) begin
                        st <= S_RX;
                        bitn <= 3'h7;
                    end else begin
                        hs <= hs + 3'h1;
                        sh <= hdr_byte(hs + 3'h1);
                        bitn <= 3'h7;
                        st <= S_TX;
                    end
                end
                S_RX: if (step) begin
                    sh <= {sh[6:0], samp};
                    bitn <= bitn - 3'h1;
                    if (bitn == 3'h0) begin
                        st <= S_HOLD;
                        rd.valid <= 1'b1;
                        rd.data <= {sh[6:0], samp};
                    end
                end
                S_MACK: if (step) begin
                    st <= ack ? S_RX : S_STOP;
                    bitn <= 3'h7;
                end
                S_STOP: if (step) begin
                    st <= S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_hi_half;
        active && phase == PH_LAST && adv;
    endsequence

    property p_scl_low_after_slot;
        s_hi_half |=> ##1 (scl_oe || $past(st) == S_IDLE);
    endproperty
    a_scl_low_after_slot: assert property (p_scl_low_after_slot)
        else $error("boot clock not low at slot start");

    property p_dev_addr;
        (st == S_TX && bitn == 3'h7 && (hs == HS_WR_ADDR || hs == HS_RD_ADDR))
            |-> sh[7:1] == EE_ADDR && sh[0] == (hs == HS_RD_ADDR);
    endproperty
    a_dev_addr: assert property (p_dev_addr)
        else $error("wrong EEPROM bus address");

endmodule

// ### logic/eeprom_self_boot_loader.sv
// Self boot sequencer: reads an instruction image from a two-wire EEPROM and
// issues register/memory writes. Assumes clk is the master clock input.
//
// Contract
// - Boot only if boot select is high and power-down has been released.
// - Boot select sampled only when leaving power-down; later changes ignored.
// - Boot bus clock is master clock divided by 64.
// - EEPROM locations addressed by two address bytes after the device byte.
// - EEPROM answers at seven-bit bus address 0x50.
// - Image checked with CRC-8, polynomial x^8 + x^2 + x + 1.
// - CRC covers byte 0 through end instruction; next byte is expected CRC.
// - 0x00 ends boot plus CRC byte, 0x03 no-op, 0x04 waits PLL lock.
// - CRC mismatch or unknown opcode aborts; retry after 250 ms at 12.288 MHz.
// - 0x02 reads 16-bit delay high first, waits delay times 2048 cycles.
// - 0x01 reads length and address, writes length minus two data bytes.
// - 0x05 reads address and one data byte, writes that byte.
// - Boot begins after 16,568 master clocks following power-down release.
`timescale 1ns/1ps
module eeprom_self_boot_loader import boot_pkg::*; #(
    parameter int unsigned WAIT_CYC = BOOT_WAIT_CYC,
    parameter int unsigned RETRY_WAIT_CYC = RETRY_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic power_down_n,
    input wire logic boot_select_pin,
    input wire logic pll_locked,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic wr_valid,
    output logic [15:0] wr_addr,
    output logic [7:0] wr_data,
    output logic boot_busy,
    output logic boot_done,
    output logic boot_fail
);

    boot_rd_if rd ();

    boot_st_t st;
    logic core_rst;
    logic pd_prev;
    logic boot_en;
    logic pend;
    logic fetch;
    logic got;
    logic [7:0] b;
    logic [7:0] crc;
    logic [7:0] op;
    logic [2:0] argn;
    logic [23:0] arg;
    logic [15:0] taddr;
    logic [15:0] dcount;
    logic [CNT_W-1:0] cnt;

    // Power-down acts as a reset of the read engine and the instruction sequencer
    assign core_rst = rst || !power_down_n;
    assign fetch = (st == M_OP) || (st == M_ARG) || (st == M_DATA) || (st == M_CRC);
    assign got = pend && rd.valid;
    assign b = rd.data;

    eeprom_read_engine u_engine (
        .clk(clk),
        .rst(core_rst),
        .rd(rd.engine),
        .scl_i(scl_i),
        .scl_o(scl_o),
        .scl_oe(scl_oe),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe(sda_oe)
    );

    // ------------------------------------------------------------
    // Boot select capture
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            pd_prev <= 1'b0;
            boot_en <= 1'b0;
        end else begin
            pd_prev <= power_down_n;
            if (!power_down_n) begin
                boot_en <= 1'b0;
            end else if (!pd_prev) begin
                boot_en <= boot_select_pin;
            end
        end
    end

    // ------------------------------------------------------------
    // Byte fetch handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (core_rst) begin
            pend <= 1'b0;
            rd.req <= 1'b0;
        end else begin
            rd.req <= fetch && !pend && !rd.valid && !rd.err;
            if (!fetch || rd.valid || rd.err) begin
                pend <= 1'b0;
            end else begin
                pend <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Instruction sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (core_rst) begin
            st <= M_OFF;
            cnt <= '0;
            crc <= CRC_INIT;
            op <= 8'h00;
            argn <= 3'h0;
            arg <= 24'h000000;
            taddr <= 16'h0000;
            dcount <= 16'h0000;
            rd.stop <= 1'b0;
            wr_valid <= 1'b0;
            wr_addr <= 16'h0000;
            wr_data <= 8'h00;
            boot_done <= 1'b0;
            boot_fail <= 1'b0;
        end else begin
            rd.stop <= 1'b0;
            wr_valid <= 1'b0;
            boot_done <= 1'b0;
            boot_fail <= 1'b0;
            if (fetch && rd.err) begin
                st <= M_ABORT;
            end else begin
                unique case (st)
                    M_OFF: if (boot_en) begin
                        st <= M_WAIT;
                        cnt <= '0;
                    end
                    M_WAIT, M_RETRY: begin
                        cnt <= cnt + CNT_W'(1);
                        if ((st == M_WAIT && cnt == CNT_W'(WAIT_CYC - 1))
                            || (st == M_RETRY && cnt == CNT_W'(RETRY_WAIT_CYC - 1))) begin
                            st <= M_OP;
                            crc <= CRC_INIT;
                        end
                    end
                    M_OP: if (got) begin
                        crc <= crc8_next(crc, b);
                        op <= b;
                        unique case (b)
                            OP_END: st <= M_CRC;
                            OP_BURST: begin
                                argn <= ARGS_BURST;
                                st <= M_ARG;
                            end
                            OP_DELAY: begin
                                argn <= ARGS_DELAY;
                                st <= M_ARG;
                            end
                            OP_NOP: st <= M_OP;
                            OP_PLL: st <= M_PLL;
                            OP_SINGLE: begin
                                argn <= ARGS_SINGLE;
                                st <= M_ARG;
                            end
                            default: begin
                                st <= M_ABORT;
                                rd.stop <= 1'b1;
                            end
                        endcase
                    end
                    M_ARG: if (got) begin
                        crc <= crc8_next(crc, b);
                        arg <= {arg[15:0], b};
                        argn <= argn - 3'h1;
                        if (argn == 3'h1) begin
                            st <= M_OP;
                            if (op == OP_BURST) begin
                                taddr <= {arg[7:0], b};
                                dcount <= arg[23:8] - 16'h0002;
                                if (arg[23:8] > 16'h0002) begin
                                    st <= M_DATA;
                                end
                            end else if (op == OP_DELAY) begin
                                cnt <= {arg[7:0], b, 11'h000};
                                st <= M_DELAY;
                            end else begin
                                wr_valid <= 1'b1;
                                wr_addr <= arg[15:0];
                                wr_data <= b;
                            end
                        end
                    end
                    M_DATA: if (got) begin
                        crc <= crc8_next(crc, b);
                        wr_valid <= 1'b1;
                        wr_addr <= taddr;
                        wr_data <= b;
                        taddr <= taddr + 16'h0001;
                        dcount <= dcount - 16'h0001;
                        if (dcount == 16'h0001) begin
                            st <= M_OP;
                        end
                    end
                    M_DELAY: begin
                        cnt <= cnt - CNT_W'(1);
                        if (cnt == '0) begin
                            st <= M_OP;
                        end
                    end
                    M_PLL: if (pll_locked) begin
                        st <= M_OP;
                    end
                    M_CRC: if (got) begin
                        rd.stop <= 1'b1;
                        st <= (b == crc) ? M_END : M_ABORT;
                    end
                    M_ABORT: if (rd.idle) begin
                        st <= M_RETRY;
                        cnt <= '0;
                        boot_fail <= 1'b1;
                    end
                    M_END: if (rd.idle) begin
                        st <= M_DONE;
                        boot_done <= 1'b1;
                    end
                    M_DONE: st <= M_DONE;
                    default: st <= M_OFF;
                endcase
            end
        end
    end

    assign boot_busy = (st != M_OFF) && (st != M_DONE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (core_rst);

    sequence s_end_op;
        got && st == M_OP && b == OP_END;
    endsequence

    sequence s_bad_crc;
        got && st == M_CRC && b != crc;
    endsequence

    property p_req_needs_sel;
        rd.req |-> boot_en;
    endproperty
    a_req_needs_sel: assert property (p_req_needs_sel)
        else $error("EEPROM read without boot select");

    property p_sel_held;
        $past(pd_prev) && pd_prev |-> $stable(boot_en);
    endproperty
    a_sel_held: assert property (p_sel_held)
        else $error("boot select changed after power-down release");

    property p_wait_full;
        (st == M_WAIT && cnt != CNT_W'(WAIT_CYC - 1)) |=> st == M_WAIT;
    endproperty
    a_wait_full: assert property (p_wait_full)
        else $error("boot started before wait elapsed");

    property p_end_to_crc;
        s_end_op |=> st == M_CRC ##0 !pend ##1 rd.req;
    endproperty
    a_end_to_crc: assert property (p_end_to_crc)
        else $error("end instruction not followed by CRC fetch");

    property p_bad_crc_retry;
        s_bad_crc |=> st == M_ABORT ##0 rd.stop;
    endproperty
    a_bad_crc_retry: assert property (p_bad_crc_retry)
        else $error("CRC mismatch did not abort");

    property p_retry_full;
        (st == M_RETRY && cnt != CNT_W'(RETRY_WAIT_CYC - 1)) |=> st == M_RETRY;
    endproperty
    a_retry_full: assert property (p_retry_full)
        else $error("retry started early");

    property p_delay_hold;
        (st == M_DELAY && cnt != '0) |=> st == M_DELAY && cnt == $past(cnt) - CNT_W'(1);
    endproperty
    a_delay_hold: assert property (p_delay_hold)
        else $error("delay ended early");

    property p_pll_wait;
        (st == M_PLL && !pll_locked) |=> st == M_PLL;
    endproperty
    a_pll_wait: assert property (p_pll_wait)
        else $error("PLL wait left without lock");

    // Last write of the running burst
    logic burst_prev_ok;
    logic [15:0] burst_prev_addr;

    always_ff @(posedge clk) begin
        if (core_rst || st != M_DATA) begin
            burst_prev_ok <= 1'b0;
            burst_prev_addr <= 16'h0000;
        end else if (wr_valid) begin
            burst_prev_ok <= 1'b1;
            burst_prev_addr <= wr_addr;
        end
    end

    property p_burst_incr;
        wr_valid && burst_prev_ok |-> wr_addr == burst_prev_addr + 16'h0001;
    endproperty
    a_burst_incr: assert property (p_burst_incr)
        else $error("burst address not consecutive");

    property p_done_quiet;
        st == M_DONE |-> !scl_oe && !sda_oe && !rd.req;
    endproperty
    a_done_quiet: assert property (p_done_quiet)
        else $error("bus driven after boot completed");

endmodule

// ### dv/eeprom_model.sv
// Behavioural serial EEPROM with two address bytes, sequential reads.
// Assumes the bench resolves the open-drain lines with pull-ups.
`timescale 1ns/1ps
module eeprom_model (
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull
);
    logic [7:0] mem [0:255];
    logic [15:0] ptr = 16'h0000;
    logic [7:0] sh = 8'h00;
    logic act = 1'b0;
    logic rd = 1'b0;
    logic refuse = 1'b0;
    int bitn = 0;
    int nbyte = 0;
    initial sda_pull = 1'b0;
    // ------------------------------------------------------------
    // Start, stop and bit slots
    // ------------------------------------------------------------
    always @(negedge sda) if (scl) begin
        act = 1'b1;
        rd = 1'b0;
        bitn = 0;
        nbyte = 0;
    end
    always @(posedge sda) if (scl) begin
        act = 1'b0;
        sda_pull = 1'b0;
    end
    always @(posedge scl) if (act) begin
        if (bitn < 8 && !rd) sh = {sh[6:0], sda};
        if (bitn == 8 && rd && sda) act = 1'b0;
        bitn = (bitn == 8) ? 0 : bitn + 1;
    end
    always @(negedge scl) if (act) begin
        sda_pull = 1'b0;
        if (bitn == 8 && !rd) begin
            if (nbyte == 0 && (refuse || sh[7:1] != 7'h50)) act = 1'b0;
            else sda_pull = 1'b1;
            if (nbyte == 0) rd = sh[0];
            if (nbyte == 1) ptr[15:8] = sh;
            if (nbyte == 2) ptr[7:0] = sh;
            nbyte++;
        end else if (rd && bitn < 8) sda_pull = ~mem[ptr[7:0]][7 - bitn];
        else if (rd) ptr++;
    end
endmodule

// ### dv/eeprom_self_boot_loader_tb.sv
// Self-checking bench for the EEPROM self boot loader.
// Assumes eeprom_model on the two-wire pins, pull-ups on both lines.
`timescale 1ns/1ps
module eeprom_self_boot_loader_tb;
    import boot_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic power_down_n = 1'b0;
    logic boot_select_pin = 1'b1;
    logic pll_locked = 1'b1;
    logic scl_o, scl_oe, sda_o, sda_oe, wr_valid, boot_busy, boot_done, boot_fail, sda_pull;
    logic [15:0] wr_addr;
    logic [7:0] wr_data;
    logic [1:0] res;
    int n;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [23:0] wq[$];
    wire scl = ~scl_oe;
    wire sda = ~(sda_oe | sda_pull);
    always #20 clk = ~clk;
    always @(posedge clk) if (wr_valid === 1'b1) wq.push_back({wr_addr, wr_data});
    eeprom_self_boot_loader #(.WAIT_CYC(20), .RETRY_WAIT_CYC(30)) i_eeprom_self_boot_loader (
        .clk(clk), .rst(rst), .power_down_n(power_down_n), .boot_select_pin(boot_select_pin),
        .pll_locked(pll_locked), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_data(wr_data), .boot_busy(boot_busy), .boot_done(boot_done), .boot_fail(boot_fail));
    eeprom_model i_eeprom_model (.scl(scl), .sda(sda), .sda_pull(sda_pull));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic load(input logic [7:0] img[$], input logic [7:0] flip);
        logic [7:0] c;
        c = 8'h00;
        foreach (img[i]) begin
            i_eeprom_model.mem[i] = img[i];
            c = c ^ img[i];
            repeat (8) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
        end
        i_eeprom_model.mem[img.size()] = c ^ flip;
    endtask
    task automatic restart(input logic sel);
        @(negedge clk);
        power_down_n = 1'b0;
        boot_select_pin = sel;
        @(negedge clk);
        power_down_n = 1'b1;
        wq.delete();
    endtask
    task automatic wait_res();
        res = 2'b00;
        for (n = 0; n < 40000 && res == 2'b00; n++) begin
            @(negedge clk);
            if (n == 20000) pll_locked = 1'b1;
            res = {boot_fail, boot_done};
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_select();
        restart(1'b0);
        @(negedge clk);
        boot_select_pin = 1'b1;
        res = 2'b00;
        repeat (2000) begin
            @(negedge clk);
            res = res | {boot_busy, scl_oe};
        end
        check({22'h0, res}, 24'h0);
    endtask
    task automatic sc_opcode();
        i_eeprom_model.refuse = 1'b1;
        restart(1'b1);
        wait_res();
        check({22'h0, res}, 24'h2);
        i_eeprom_model.refuse = 1'b0;
        load('{8'h03, 8'h06}, 8'h00);
        restart(1'b1);
        wait_res();
        check({22'h0, res}, 24'h2);
        check(24'(boot_busy), 24'h1);
    endtask
    task automatic sc_crc();
        load('{8'h05, 8'h00, 8'h07, 8'h5A, 8'h00}, 8'h01);
        restart(1'b1);
        wait_res();
        check({22'h0, res}, 24'h2);
        load('{8'h05, 8'h00, 8'h07, 8'h5A, 8'h00}, 8'h00);
        wq.delete();
        wait_res();
        check({22'h0, res}, 24'h1);
        check(wq[0], 24'h00075A);
    endtask
    task automatic sc_image();
        load('{8'h03, 8'h05, 8'h12, 8'h34, 8'hA5, 8'h01, 8'h00, 8'h04, 8'h20, 8'h00, 8'h11,
            8'h22, 8'h02, 8'h00, 8'h01, 8'h04, 8'h00}, 8'h00);
        pll_locked = 1'b0;
        restart(1'b1);
        wait_res();
        check({22'h0, res}, 24'h1);
        check(24'(n > 20000), 24'h1);
        check(24'(wq.size()), 24'h3);
        check(wq[0], 24'h1234A5);
        check(wq[1], 24'h200011);
        check(wq[2], 24'h200122);
        res = 2'b00;
        repeat (3000) begin
            @(negedge clk);
            res = res | {scl_oe | sda_oe, boot_busy | scl_o | sda_o};
        end
        check({22'h0, res}, 24'h0);
    endtask
    task automatic test_done();
        $display("errors %0d, comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        sc_select();
        sc_opcode();
        sc_crc();
        sc_image();
        test_done();
    end
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        test_done();
    end
endmodule
